/* pllcc_top.sv */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - The feedback counter divides by the written divisor, 9 to 4111.
// - The VCO output passes a post-divider of one, two or four.
// - The coarse delay code 00..11 gives one to four whole clocks.
// - Fine delay code 0..31 gives one to thirty-two sixteenths of a clock.
// - The pump current code picks 100 uA, 400 uA or 1.6 mA.
// - Pump current code 01 acts exactly like code 00.
// - Sync, delayed sync and phase detector polarity bits, 1 is positive.
// - With readback selected the control bits are shifted out serially.
// - Chip enable stops and clears only the post-divider and feedback counter; delayed sync keeps running.
// - VCO bypass off routes the counter for direct test.
// - Each of the seven single-ended outputs has its own enable.
// - Differential outputs always drive; single-ended ones only if enabled.
module pllcc_top
  import pllcc_pkg::*;
(
  // Clock and reset.
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Sync input and VCO test input.
  input  wire logic        SYNC_IN,
  input  wire logic        VCO_TEST_IN,
  // Single-ended outputs with enables.
  output logic [6:0]       SE_OUT,
  output logic [6:0]       SE_OE,
  // Differential outputs, pump controls, readback and interrupt.
  output logic             PIXEL_CLOCK_DIFF,
  output logic             DELAYED_SYNC_DIFF,
  output logic             PUMP_UP,
  output logic [1:0]       PUMP_CURRENT,
  output logic             READBACK_SERIAL_OUT,
  output logic             IRQ
);

  typedef enum logic [1:0] {RB_IDLE = 2'b00, RB_SHIFT = 2'b01} pllcc_rb_e;

  pllcc_ctrl_s ctrl;
  logic [12:0] divisor;
  logic [6:0]  out_en;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [1:0]  sync_meta, vco_meta;
  logic        sync_s, sync_d, vco_s;
  logic [12:0] fb_count;
  logic [1:0]  post_count;
  logic        post_clk;
  logic        fb_wrap;
  logic [9:0]  delay_count;
  logic        delay_busy;
  logic        delayed_sync_out;
  logic        half_clk;
  pllcc_rb_e   rb_state;
  logic [4:0]  rb_idx;
  logic [CTRL_BITS-1:0] rb_shift;
  logic        wr, rd, sync_edge, div_ok;
  logic        delayed_sync_out_fire;
  logic [1:0]  irq_set, irq_clr;

  function automatic logic [12:0] clamp_div(input logic [12:0] v);
    if (v < DIV_MIN) begin
      return DIV_MIN;
    end
    if (v > DIV_MAX) begin
      return DIV_MAX;
    end
    return v;
  endfunction

  function automatic logic [1:0] post_mask(input logic [1:0] code);
    unique case (code)
      POST_DIV2: return 2'h1;
      POST_DIV4: return 2'h3;
      default:   return 2'h0;
    endcase
  endfunction

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign sync_edge = sync_s && !sync_d;
  assign div_ok = 1'b1;
  assign delayed_sync_out_fire = delay_busy && (delay_count <= STEP_PER_CLK);

  //////////////////////////////////////////////////////////////////////////
  // Register bank. Answers in the access cycle; unmapped reads give zero.

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      divisor <= DIV_RESET;
      ctrl    <= CTRL_RESET;
      out_en  <= 7'h00;
      irq_mask <= 2'h0;
    end else if (wr) begin
      unique case (PADDR)
        ADDR_DIVISOR: divisor <= clamp_div(PWDATA[12:0]);
        ADDR_CTRL:    ctrl <= pllcc_ctrl_s'(PWDATA[CTRL_BITS-1:0]);
        ADDR_OUTEN:   out_en <= PWDATA[6:0];
        ADDR_IRQ_MSK: irq_mask <= PWDATA[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PRDATA <= 32'h0;
    end else if (rd) begin
      unique case (PADDR)
        ADDR_DIVISOR: PRDATA <= {19'h0, divisor};
        ADDR_CTRL:    PRDATA <= {15'h0, ctrl};
        ADDR_OUTEN:   PRDATA <= {25'h0, out_en};
        ADDR_STATUS:  PRDATA <= {19'h0, fb_count};
        ADDR_IRQ_ST:  PRDATA <= {30'h0, irq_status};
        ADDR_IRQ_MSK: PRDATA <= {30'h0, irq_mask};
        default:      PRDATA <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sync_meta <= 2'h0;
      vco_meta  <= 2'h0;
      sync_d    <= 1'b0;
    end else begin
      sync_meta <= {sync_meta[0], SYNC_IN};
      vco_meta  <= {vco_meta[0], VCO_TEST_IN};
      sync_d    <= sync_s;
    end
  end

  // Sync polarity is applied after the second flop.
  assign sync_s = ctrl.pol_sync ? sync_meta[1] : !sync_meta[1];
  assign vco_s  = vco_meta[1];

  //////////////////////////////////////////////////////////////////////////
  // Post-divider and feedback counter. The VCO itself is modelled by the
  // reference clock; with bypass off the test input drives the counter.

  always_ff @(posedge REF_CLK) begin
    if (RST || !ctrl.chip_function_enable) begin
      post_count <= 2'h0;
    end else begin
      post_count <= (post_count + 2'h1) & post_mask(ctrl.post_div);
    end
  end

  assign post_clk = ctrl.vco_bypass ? (post_count == 2'h0) : vco_s;

  always_ff @(posedge REF_CLK) begin
    if (RST || !ctrl.chip_function_enable) begin
      fb_count <= 13'h0;
      fb_wrap  <= 1'b0;
      half_clk <= 1'b0;
    end else begin
      fb_wrap <= 1'b0;
      if (post_clk) begin
        half_clk <= !half_clk;
        if (fb_count >= divisor - 13'h1) begin
          fb_count <= 13'h0;
          fb_wrap  <= 1'b1;
        end else begin
          fb_count <= fb_count + 13'h1;
        end
      end
    end
  end

  // Phase detector: leading counter wrap versus sync edge.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PUMP_UP <= 1'b0;
      PUMP_CURRENT <= PUMP_100UA;
    end else begin
      if (sync_edge && ctrl.pol_phase_detector) begin
        PUMP_UP <= fb_count > (divisor >> 1);
      end else if (sync_edge) begin
        PUMP_UP <= fb_count <= (divisor >> 1);
      end
      if (ctrl.pump_current == PUMP_UNUSED) begin
        PUMP_CURRENT <= PUMP_100UA;
      end else begin
        PUMP_CURRENT <= ctrl.pump_current;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Delayed sync in sixteenths of a clock.

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      delay_count <= 10'h0;
      delay_busy  <= 1'b0;
      delayed_sync_out       <= 1'b0;
    end else if (sync_edge) begin
      // Coarse whole clocks plus fine sixteenths, counted down per clock.
      delay_count <= {({4'h0, ctrl.coarse} + 6'h1), 4'h0}
                   + {5'h0, ctrl.fine} + 10'h1;
      delay_busy  <= 1'b1;
      delayed_sync_out       <= 1'b0;
    end else if (delay_busy) begin
      if (delayed_sync_out_fire) begin
        delay_busy <= 1'b0;
        delayed_sync_out      <= 1'b1;
      end else begin
        delay_count <= delay_count - STEP_PER_CLK;
      end
    end else if (!sync_s) begin
      delayed_sync_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control bit readback shifter.

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rb_state <= RB_IDLE;
      rb_idx   <= 5'h0;
      rb_shift <= '0;
      READBACK_SERIAL_OUT <= 1'b0;
    end else begin
      unique case (rb_state)
        RB_IDLE: begin
          READBACK_SERIAL_OUT <= 1'b0;
          if (ctrl.readback_select) begin
            rb_state <= RB_SHIFT;
            rb_shift <= ctrl;
            rb_idx   <= 5'h0;
          end
        end
        RB_SHIFT: begin
          READBACK_SERIAL_OUT <= rb_shift[CTRL_BITS-1];
          rb_shift <= {rb_shift[CTRL_BITS-2:0], 1'b0};
          rb_idx   <= rb_idx + 5'h1;
          if (rb_idx == RB_LAST) begin
            rb_state <= RB_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs and interrupts.

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      SE_OUT <= 7'h00;
      SE_OE  <= 7'h00;
      PIXEL_CLOCK_DIFF  <= 1'b0;
      DELAYED_SYNC_DIFF <= 1'b0;
    end else begin
      PIXEL_CLOCK_DIFF  <= post_clk;
      DELAYED_SYNC_DIFF <= ctrl.pol_delayed_sync_out ? delayed_sync_out : !delayed_sync_out;
      SE_OUT <= {fb_wrap, !div_ok, ctrl.pol_delayed_sync_out ? delayed_sync_out : !delayed_sync_out,
                 half_clk, !half_clk, post_clk, !post_clk};
      SE_OE  <= out_en;
    end
  end

  always_comb begin
    irq_set              = 2'h0;
    irq_set[ST_DIV_WRAP] = fb_wrap;
    irq_set[ST_SYNC_OUT] = delayed_sync_out_fire;
  end

  assign irq_clr = (wr && PADDR == ADDR_IRQ_ST) ? PWDATA[1:0] : 2'h0;

  // Set wins over a write-one clear, so no event is lost to a late clear.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      irq_status <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      IRQ <= |(irq_status & irq_mask);
    end
  end

  chk_pump_alias: assert property (@(posedge REF_CLK) disable iff (RST)
    (ctrl.pump_current == PUMP_UNUSED) |=> PUMP_CURRENT == PUMP_100UA)
    else $error("pump code 01 not treated as 00");
  chk_div_range: assert property (@(posedge REF_CLK) disable iff (RST)
    divisor >= DIV_MIN && divisor <= DIV_MAX)
    else $error("divisor out of range");
  chk_oe_follow: assert property (@(posedge REF_CLK) disable iff (RST)
    $changed(out_en) |=> SE_OE == $past(out_en))
    else $error("output enable not following register");
  chk_off_stops: assert property (@(posedge REF_CLK) disable iff (RST)
    !ctrl.chip_function_enable |=> fb_count == 13'h0)
    else $error("counter runs while disabled");
  chk_delayed_sync_out_delay: assert property (@(posedge REF_CLK) disable iff (RST)
    (sync_edge && ctrl.coarse == 2'h0 && ctrl.fine == 5'h0
     && $stable(ctrl)) |=> ##[1:3] delayed_sync_out)
    else $error("delayed sync late");
  chk_readback_go: assert property (@(posedge REF_CLK) disable iff (RST)
    (rb_state == RB_IDLE && ctrl.readback_select)
    |=> rb_state == RB_SHIFT)
    else $error("readback did not start");
  chk_post_div1: assert property (@(posedge REF_CLK) disable iff (RST)
    (ctrl.post_div == POST_DIV1 && ctrl.vco_bypass) |=> post_count == 2'h0)
    else $error("divide by one not held");
  chk_diff_clk: assert property (@(posedge REF_CLK) disable iff (RST)
    !RST |=> PIXEL_CLOCK_DIFF == $past(post_clk))
    else $error("differential clock not driven");

endmodule

`default_nettype wire

/* pllcc_pkg.sv */
package pllcc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_DIVISOR = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_OUTEN   = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;

  // Divisor limits.
  localparam logic [12:0] DIV_MIN   = 13'h0009;
  localparam logic [12:0] DIV_MAX   = 13'h100f;
  localparam logic [12:0] DIV_RESET = 13'h0540;

  // Post-divider codes.
  localparam logic [1:0] POST_DIV1 = 2'h0;
  localparam logic [1:0] POST_DIV2 = 2'h1;
  localparam logic [1:0] POST_DIV4 = 2'h2;

  // Pump current codes.
  localparam logic [1:0] PUMP_100UA = 2'h0;
  localparam logic [1:0] PUMP_UNUSED = 2'h1;
  localparam logic [1:0] PUMP_400UA = 2'h2;
  localparam logic [1:0] PUMP_1M6A  = 2'h3;

  localparam logic [4:0] FINE_RESET = 5'h0a;
  localparam int         CTRL_BITS  = 17;
  localparam logic [4:0] RB_LAST    = 5'h10;
  // Sixteenths of a clock counted off by the delay counter each cycle.
  localparam logic [9:0] STEP_PER_CLK = 10'h010;

  // Status and interrupt bit positions.
  localparam int ST_DIV_WRAP = 0;
  localparam int ST_SYNC_OUT = 1;

  typedef struct packed {
    logic       readback_select;
    logic       chip_function_enable;
    logic       vco_bypass;
    logic       pol_sync;
    logic       pol_delayed_sync_out;
    logic       pol_phase_detector;
    logic [1:0] pump_current;
    logic [1:0] coarse;
    logic [4:0] fine;
    logic [1:0] post_div;
  } pllcc_ctrl_s;

  localparam pllcc_ctrl_s CTRL_RESET = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
    1'b1, PUMP_400UA, 2'h0, FINE_RESET, POST_DIV2};

endpackage

/* pllcc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module pllcc_host
  import pllcc_pkg::*;
(
  // Bus clock and slave answer.
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  // Master request.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  // One transfer; the answer is taken at the rising edge that samples pready.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data must not keep looking valid.
    pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

/* tb_pll_clock_config_controls.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_pll_clock_config_controls
  import pllcc_pkg::*;
;
  logic        clk, rst, sel, en, wr, pready, pslverr, sync_in;
  logic        vco = 1'b0;
  logic        pix, dsy, pup, rbo, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [6:0]  se_out, se_oe;
  logic [1:0]  pump;
  int          bad_count, compares;
  pllcc_ctrl_s c;

  pllcc_top u_pllcc_top (.REF_CLK(clk), .RST(rst), .PSEL(sel),
    .PENABLE(en), .PWRITE(wr), .PADDR(addr), .PWDATA(wdata),
    .PRDATA(rdata), .PREADY(pready), .PSLVERR(pslverr),
    .SYNC_IN(sync_in), .VCO_TEST_IN(vco), .SE_OUT(se_out),
    .SE_OE(se_oe), .PIXEL_CLOCK_DIFF(pix), .DELAYED_SYNC_DIFF(dsy),
    .PUMP_UP(pup), .PUMP_CURRENT(pump), .READBACK_SERIAL_OUT(rbo),
    .IRQ(irq));
  pllcc_host u_pllcc_host (.clk(clk), .pready(pready), .prdata(rdata),
    .psel(sel), .penable(en), .pwrite(wr), .paddr(addr),
    .pwdata(wdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) vco <= ~vco;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    u_pllcc_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd32(input logic [7:0] a, input logic [31:0] e);
    u_pllcc_host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic complete_run;
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    rd32(ADDR_DIVISOR, {19'h0, DIV_RESET});
    rd32(ADDR_CTRL, {15'h0, CTRL_RESET});
    rd32(ADDR_OUTEN, 32'h0);
    chk({25'h0, se_oe}, 32'h0);
  endtask
  task automatic t_divisor;
    logic [12:0] w[4] = '{13'd8, 13'd4112, 13'd9, 13'd256};
    logic [12:0] e[4] = '{13'd9, 13'd4111, 13'd9, 13'd256};
    for (int i = 0; i < 4; i++) begin
      wr32(ADDR_DIVISOR, {19'h0, w[i]});
      rd32(ADDR_DIVISOR, {19'h0, e[i]});
    end
  endtask
  task automatic t_ctrl;
    // Polarity bits stay positive outside test mode.
    c = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, PUMP_1M6A, 2'h2, 5'h13,
          POST_DIV4};
    wr32(ADDR_CTRL, {15'h0, c});
    rd32(ADDR_CTRL, {15'h0, c});
    for (int i = 0; i < 4; i++) begin
      c.pump_current = 2'(i);
      wr32(ADDR_CTRL, {15'h0, c});
      repeat (2) @(posedge clk);
      chk({30'h0, pump}, (i == 1) ? 32'h0 : 32'(i));
    end
  endtask
  task automatic t_outen;
    logic [6:0] v[3] = '{7'h55, 7'h2a, 7'h7f};
    for (int i = 0; i < 3; i++) begin
      wr32(ADDR_OUTEN, {25'h0, v[i]});
      rd32(ADDR_OUTEN, {25'h0, v[i]});
      chk({25'h0, se_oe}, {25'h0, v[i]});
    end
    wr32(8'h40, 32'hffff_ffff);
    rd32(8'h40, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
  endtask
  task automatic t_irq;
    wr32(ADDR_DIVISOR, 32'd9);
    wr32(ADDR_IRQ_MSK, 32'h3);
    sync_in <= 1'b1;
    repeat (4) @(posedge clk);
    sync_in <= 1'b0;
    repeat (60) @(posedge clk);
    rd32(ADDR_IRQ_ST, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr32(ADDR_IRQ_MSK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // The counter is stopped so the wrap event cannot set again.
    c.chip_function_enable = 1'b0;
    wr32(ADDR_CTRL, {15'h0, c});
    repeat (4) @(posedge clk);
    wr32(ADDR_IRQ_ST, 32'h3);
    rd32(ADDR_IRQ_ST, 32'h0);
  endtask
  task automatic t_delayed_sync_out;
    logic [1:0] crs[3] = '{2'h0, 2'h1, 2'h3};
    logic [4:0] fin[3] = '{5'h00, 5'h10, 5'h1f};
    int         n;
    int         e;
    // The counter stays stopped, so it never leads sync.
    for (int i = 0; i < 3; i++) begin
      c.coarse             = crs[i];
      c.fine               = fin[i];
      c.pol_phase_detector = (i != 2);
      wr32(ADDR_CTRL, {15'h0, c});
      repeat (4) @(posedge clk);
      // Two sync stages, the edge and the output register add five clocks.
      e = 5 + ((int'(crs[i]) + 1) * 16 + int'(fin[i]) + 16) / 16;
      sync_in <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (dsy !== 1'b1 && n < 40);
      chk(32'(n), 32'(e));
      chk({31'h0, se_out[4]}, 32'h1);
      chk({31'h0, pup}, {31'h0, i == 2});
      sync_in <= 1'b0;
      repeat (8) @(posedge clk);
      chk({31'h0, dsy}, 32'h0);
    end
    c.pol_phase_detector = 1'b1;
  endtask
  task automatic t_post_div;
    logic [1:0] code[4] = '{POST_DIV1, POST_DIV2, POST_DIV4, 2'h3};
    int         ratio[4] = '{1, 2, 4, 1};
    int         hi;
    int         hs;
    int         hn;
    wr32(ADDR_DIVISOR, 32'd256);
    rd32(ADDR_DIVISOR, 32'd256);
    c.chip_function_enable = 1'b1;
    c.vco_bypass           = 1'b1;
    for (int i = 0; i < 4; i++) begin
      c.post_div = code[i];
      wr32(ADDR_CTRL, {15'h0, c});
      repeat (4) @(posedge clk);
      hi = 0;
      hs = 0;
      hn = 0;
      for (int k = 0; k < 16; k++) begin
        @(posedge clk);
        hi += (pix === 1'b1) ? 1 : 0;
        hs += (se_out[1] === 1'b1) ? 1 : 0;
        hn += (se_out[0] === 1'b1) ? 1 : 0;
      end
      chk(32'(hi), 32'(16 / ratio[i]));
      chk(32'(hs), 32'(16 / ratio[i]));
      chk(32'(hn), 32'(16 - 16 / ratio[i]));
    end
  endtask
  task automatic t_readback;
    logic [63:0] s;
    logic        hit;
    hit = 1'b0;
    c.readback_select = 1'b1;
    wr32(ADDR_CTRL, {15'h0, c});
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      s = {s[62:0], rbo};
    end
    for (int i = 0; i < 48; i++)
      if (s[i +: 17] === 17'(c)) hit = 1'b1;
    chk({31'h0, hit}, 32'h1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    compares  = 0;
    rst       = 1'b1;
    sync_in   = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_divisor();
    t_ctrl();
    t_outen();
    t_irq();
    t_delayed_sync_out();
    t_post_div();
    t_readback();
    complete_run();
  end
  initial begin
    #500000;
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
